// file: src/gp_out_pkg.sv
package gp_out_pkg;
  localparam int SEL_W = 6;
  localparam int CFG_W = 8;
  localparam int CFG_INV_BIT = 6;
  localparam int CFG_TEMP_BIT = 7;
  localparam logic [5:0] SEL_RXFIFO_THR = 6'h00;
  localparam logic [5:0] SEL_PLL_LOCK = 6'h0A;
  localparam logic [5:0] SEL_SLEEP_LIMIT = 6'h20;
  localparam logic [5:0] SEL_HI_Z = 6'h2E;
  localparam logic [5:0] SEL_LOW = 6'h2F;
  localparam logic [5:0] SEL_CLK_DIV = 6'h3F;
  localparam logic [7:0] CFG0_RESET = 8'h3F;
  localparam logic [7:0] CFG1_RESET = 8'h2E;
  localparam logic [7:0] CFG2_RESET = 8'h29;
  localparam logic [7:0] CFG_TEMP_SENSOR = 8'h80;
  localparam int CLK_DIV_RATIO = 192;
  localparam int HALF_DIV = CLK_DIV_RATIO / 2;
  localparam logic [6:0] HALF_DIV_LAST = 7'(HALF_DIV - 1);
endpackage

// file: src/general_output_pin_select.sv
`timescale 1ns/1ps
module general_output_pin_select (
  input wire logic clock,
  input wire logic rst,
  input wire logic cfg_write,
  input wire logic [1:0] cfg_pin,
  input wire logic [gp_out_pkg::CFG_W-1:0] cfg_data,
  input wire logic sleep_state,
  input wire logic chip_ready_n,
  input wire logic chip_select_n,
  input wire logic spi_data_out,
  input wire logic spi_data_oe,
  input wire logic rx_fifo_at_threshold,
  input wire logic pll_lock,
  input wire logic [31:0] status_signals,
  output logic gp_out_pin0,
  output logic gp_out_pin0_oe,
  output logic gp_out_pin1,
  output logic gp_out_pin1_oe,
  output logic gp_out_pin2,
  output logic gp_out_pin2_oe,
  output logic temp_sensor_enable
);
  import gp_out_pkg::*;

  logic [CFG_W-1:0] cfg_r [3];
  logic [CFG_W-1:0] cfg_nxt [3];
  logic [6:0] div_cnt_r, div_cnt_nxt;
  logic div_clk_r, div_clk_nxt;
  logic held_r, held_nxt;
  logic [2:0] pin_r, pin_nxt, oe_r, oe_nxt;
  logic temp_r, temp_nxt;

  // Pick the raw digital signal for a select value
  function automatic logic pick(input logic [5:0] sel, input logic divclk,
                                input logic rxthr, input logic lock,
                                input logic [31:0] st);
    logic v;
    v = 1'b0;
    if (sel == SEL_RXFIFO_THR) begin
      v = rxthr;
    end else if (sel == SEL_PLL_LOCK) begin
      v = lock;
    end else if (sel == SEL_CLK_DIV) begin
      v = divclk;
    end else if (sel < SEL_SLEEP_LIMIT) begin
      v = st[sel[4:0]];
    end else if (sel == SEL_LOW) begin
      v = 1'b0;
    end else begin
      v = st[sel[4:0]];
    end
    return v;
  endfunction

  always_comb begin
    logic wr0;
    wr0 = 1'b0;
    for (int i = 0; i < 3; i++) begin
      cfg_nxt[i] = cfg_r[i];
    end
    if (cfg_write && cfg_pin != 2'h3) begin
      cfg_nxt[cfg_pin] = cfg_data;
      wr0 = (cfg_pin == 2'h0);
    end
    temp_nxt = wr0 ? (cfg_data == CFG_TEMP_SENSOR) : temp_r;
  end

  // divide by 192, half period toggles
  always_comb begin
    div_cnt_nxt = (div_cnt_r == HALF_DIV_LAST) ? 7'h00 : div_cnt_r + 7'h01;
    div_clk_nxt = (div_cnt_r == HALF_DIV_LAST) ? ~div_clk_r : div_clk_r;
  end

  // hold forced levels until ready low after wake
  always_comb begin
    held_nxt = held_r;
    if (sleep_state) begin
      held_nxt = 1'b1;
    end else if (!chip_ready_n) begin
      held_nxt = 1'b0;
    end
  end

  always_comb begin
    logic [5:0] sel;
    logic inv;
    sel = 6'h00;
    inv = 1'b0;
    for (int i = 0; i < 3; i++) begin
      sel = cfg_r[i][SEL_W-1:0];
      inv = cfg_r[i][CFG_INV_BIT];
      pin_nxt[i] = pick(sel, div_clk_r, rx_fifo_at_threshold, pll_lock, status_signals) ^ inv;
      oe_nxt[i] = 1'b1;
      // forced sleep levels; high selects keep working
      if ((sleep_state || held_r) && sel < SEL_SLEEP_LIMIT) begin
        pin_nxt[i] = (i == 1) ? ~inv : inv;
      end
    end
    // Analog sensor owns pin 0, digital driver released
    if (temp_r) begin
      oe_nxt[0] = 1'b0;
    end
    // pin 1 high impedance when SEL_HI_Z is selected, unless chip select is low
    if (cfg_r[1][SEL_W-1:0] == SEL_HI_Z) begin
      oe_nxt[1] = 1'b0;
      pin_nxt[1] = 1'b0;
    end
    // serial side owns the shared pin while selected
    if (!chip_select_n) begin
      pin_nxt[1] = spi_data_out;
      oe_nxt[1] = spi_data_oe;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      // pin 1 tri-stated, pin 0 divided clock
      cfg_r[0] <= CFG0_RESET;
      cfg_r[1] <= CFG1_RESET;
      cfg_r[2] <= CFG2_RESET;
      div_cnt_r <= 7'h00;
      div_clk_r <= 1'b0;
      held_r <= 1'b0;
      pin_r <= 3'h0;
      oe_r <= 3'h0;
      temp_r <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        cfg_r[i] <= cfg_nxt[i];
      end
      div_cnt_r <= div_cnt_nxt;
      div_clk_r <= div_clk_nxt;
      held_r <= held_nxt;
      pin_r <= pin_nxt;
      oe_r <= oe_nxt;
      temp_r <= temp_nxt;
    end
  end

  assign gp_out_pin0 = pin_r[0];
  assign gp_out_pin1 = pin_r[1];
  assign gp_out_pin2 = pin_r[2];
  assign gp_out_pin0_oe = oe_r[0];
  assign gp_out_pin1_oe = oe_r[1];
  assign gp_out_pin2_oe = oe_r[2];
  assign temp_sensor_enable = temp_r;

  chk_pin1_hiz_default:
  assert property (@(posedge clock) disable iff (rst)
    (chip_select_n && $past(chip_select_n) && cfg_r[1][5:0] == SEL_HI_Z) |=> !gp_out_pin1_oe)
    else $error("pin 1 driven while high impedance selected");
  chk_sleep_force_pin0:
  assert property (@(posedge clock) disable iff (rst)
    (sleep_state && cfg_r[0][5:0] < SEL_SLEEP_LIMIT) |=> gp_out_pin0 == $past(cfg_r[0][6]))
    else $error("pin 0 not forced in sleep");
  chk_sleep_force_pin2:
  assert property (@(posedge clock) disable iff (rst)
    (sleep_state && cfg_r[2][5:0] < SEL_SLEEP_LIMIT) |=> gp_out_pin2 == $past(cfg_r[2][6]))
    else $error("pin 2 not forced in sleep");
  chk_hold_until_ready:
  assert property (@(posedge clock) disable iff (rst)
    (held_r && !sleep_state && chip_ready_n) |=> held_r)
    else $error("hold released before chip ready");
  chk_divider_period:
  assert property (@(posedge clock) disable iff (rst)
    $rose(div_clk_r) |-> ##96 $fell(div_clk_r) ##96 $rose(div_clk_r))
    else $error("divided clock period not 192");
  chk_temp_enable:
  assert property (@(posedge clock) disable iff (rst)
    (cfg_write && cfg_pin == 2'h0 && cfg_data == CFG_TEMP_SENSOR) |=> ##1 !gp_out_pin0_oe)
    else $error("temperature mode did not release pin 0");
  chk_lock_route:
  assert property (@(posedge clock) disable iff (rst)
    (!sleep_state && !held_r && cfg_r[2][5:0] == SEL_PLL_LOCK)
      |=> gp_out_pin2 == ($past(pll_lock) ^ $past(cfg_r[2][6])))
    else $error("lock detector not routed");
  chk_rx_thr_route:
  assert property (@(posedge clock) disable iff (rst)
    (!sleep_state && !held_r && cfg_r[2][5:0] == SEL_RXFIFO_THR)
      |=> gp_out_pin2 == ($past(rx_fifo_at_threshold) ^ $past(cfg_r[2][6])))
    else $error("receive threshold not routed");
  chk_high_sel_sleep:
  assert property (@(posedge clock) disable iff (rst)
    (sleep_state && cfg_r[0][5:0] == SEL_CLK_DIV && !temp_r)
      |=> gp_out_pin0 == ($past(div_clk_r) ^ $past(cfg_r[0][6])))
    else $error("high select forced in sleep");
  chk_serial_owns_pin1:
  assert property (@(posedge clock) disable iff (rst)
    !chip_select_n |=> gp_out_pin1 == $past(spi_data_out))
    else $error("serial data not on pin 1");
  chk_reset_pin1_off:
  assert property (@(posedge clock)
    ($fell(rst) && chip_select_n) |=> !gp_out_pin1_oe)
    else $error("pin 1 driven after reset");
  chk_temp_flag:
  assert property (@(posedge clock) disable iff (rst)
    (cfg_write && cfg_pin == 2'h0) |=> temp_sensor_enable == ($past(cfg_data) == CFG_TEMP_SENSOR))
    else $error("temperature flag does not follow pin 0 config");
  chk_sleep_force_pin1:
  assert property (@(posedge clock) disable iff (rst)
    (sleep_state && chip_select_n && cfg_r[1][SEL_W-1:0] < SEL_SLEEP_LIMIT)
      |=> gp_out_pin1 == ~$past(cfg_r[1][CFG_INV_BIT]))
    else $error("pin 1 not forced in sleep");
endmodule

// file: dv/host_mcu_model.sv
`timescale 1ns/1ps
module host_mcu_model (
  input wire logic clock,
  input wire logic pin_level,
  input wire logic pin_oe,
  output logic seen,
  output int period
);
  int cnt = 0;
  logic drv_last = 1'b0;
  logic prev = 1'b0;
  // No pull on the wire: a released pin shows the inverse of its last driven level
  assign seen = pin_oe ? pin_level : ~drv_last;
  always @(posedge clock) begin
    if (pin_oe) begin
      drv_last <= pin_level;
    end
    prev <= seen;
    cnt <= cnt + 1;
    if (seen && !prev) begin
      period <= cnt + 1;
      cnt <= 0;
    end
  end
endmodule

// file: dv/general_output_pin_select_tb_top.sv
`timescale 1ns/1ps
module general_output_pin_select_tb_top;
  import gp_out_pkg::*;
  logic clock = 0, rst = 1, cfg_write = 0, sleep_state = 0, chip_ready_n = 0;
  logic chip_select_n = 1, spi_data_out = 0, spi_data_oe = 0, rx = 0, pll = 0;
  logic [1:0] cfg_pin = 0;
  logic [7:0] cfg_data = 0;
  logic [31:0] st = 32'h0;
  logic p0, p0_oe, p1, p1_oe, p2, p2_oe, temp, seen;
  int period, num_errors = 0, checks = 0, cycles = 0;
  always #50 clock = ~clock;
  general_output_pin_select dut_u (.clock(clock), .rst(rst), .cfg_write(cfg_write),
    .cfg_pin(cfg_pin), .cfg_data(cfg_data), .sleep_state(sleep_state),
    .chip_ready_n(chip_ready_n), .chip_select_n(chip_select_n),
    .spi_data_out(spi_data_out), .spi_data_oe(spi_data_oe), .rx_fifo_at_threshold(rx),
    .pll_lock(pll), .status_signals(st), .gp_out_pin0(p0), .gp_out_pin0_oe(p0_oe),
    .gp_out_pin1(p1), .gp_out_pin1_oe(p1_oe), .gp_out_pin2(p2), .gp_out_pin2_oe(p2_oe),
    .temp_sensor_enable(temp));
  host_mcu_model host_u (.clock(clock), .pin_level(p0), .pin_oe(p0_oe), .seen(seen),
    .period(period));
  task automatic final_report();
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic wt();
    repeat (2) @(negedge clock);
  endtask
  task automatic wr(input logic [1:0] p, input logic [7:0] d);
    @(negedge clock);
    cfg_write = 1;
    cfg_pin = p;
    cfg_data = d;
    @(negedge clock);
    cfg_write = 0;
    wt();
  endtask
  task automatic t_defaults();
    repeat (450) @(negedge clock);
    chk("pin1_oe", 1'b0, p1_oe);
    chk("pin0_oe", 1'b1, p0_oe);
    chk("pin2_oe", 1'b1, p2_oe);
    checks++;
    if (period !== CLK_DIV_RATIO) begin
      num_errors++;
      $display("Error pin0 period expected %0d seen %0d", CLK_DIV_RATIO, period);
    end
  endtask
  task automatic t_select();
    wr(2, 8'h00);
    rx = 1;
    wt();
    chk("pin2 thr", 1'b1, p2);
    rx = 0;
    wt();
    chk("pin2 thr", 1'b0, p2);
    wr(2, 8'h0A);
    pll = 1;
    wt();
    chk("pin2 lock", 1'b1, p2);
    wr(2, 8'h4A);
    chk("pin2 inv", 1'b0, p2);
    wr(0, 8'h2F);
    // One look could meet the old clock low by chance
    repeat (200) begin
      @(negedge clock);
      chk("pin0 low", 1'b0, p0);
    end
    wr(0, CFG_TEMP_SENSOR);
    chk("temp", 1'b1, temp);
    chk("pin0_oe", 1'b0, p0_oe);
    chk("host pin0", 1'b1, seen);
    sleep_state = 1;
    wt();
    chk("pin2 forced", 1'b1, p2);
    sleep_state = 0;
    wt();
  endtask
  task automatic t_sleep();
    pll = 0;
    rx = 1;
    st = 32'h0000_0002;
    wr(0, 8'h21);
    wr(1, 8'h0A);
    wr(2, 8'h40);
    chip_ready_n = 1;
    sleep_state = 1;
    wt();
    chk("pin1 sleep", 1'b1, p1);
    chk("pin2 sleep", 1'b1, p2);
    chk("pin0 sleep", 1'b1, p0);
    sleep_state = 0;
    wt();
    chk("pin1 held", 1'b1, p1);
    chk("pin2 held", 1'b1, p2);
    chip_ready_n = 0;
    wt();
    chk("pin1 awake", 1'b0, p1);
    chk("pin2 awake", 1'b0, p2);
  endtask
  task automatic t_serial();
    wr(1, 8'h2E);
    wr(0, 8'h3F);
    sleep_state = 1;
    wt();
    chk("pin1_oe sleep", 1'b0, p1_oe);
    sleep_state = 0;
    chip_select_n = 0;
    spi_data_oe = 1;
    wt();
    chk("pin1_oe sel", 1'b1, p1_oe);
    chk("pin1 ready", 1'b0, p1);
    spi_data_out = 1;
    wt();
    chk("pin1 data", 1'b1, p1);
    chip_select_n = 1;
    wt();
    chk("pin1_oe idle", 1'b0, p1_oe);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(negedge clock);
    rst = 0;
    t_defaults();
    t_select();
    t_sleep();
    t_serial();
    final_report();
  end
endmodule
